// *** core/itx_decode.sv ***
/*
 * Address decoder of the interval timer one block: turns a bus access into one-cycle strobes.
 * Assumes the select, direction and offset inputs are synchronous to the block clock.
 */
`timescale 1ns/1ps
`include "itx_map.svh"

module itx_decode (
    input  wire logic            bus_cs,    // Access strobe, one cycle per access.
    input  wire logic            bus_rd,    // High for a read, low for a write.
    input  wire logic [3:0]      bus_addr,  // Register offset.
    output itx_pkg::itx_acc_t    acc        // Decoded strobes.
);

    // *****************************************************************
    // Offset match, used once for each offset that a strobe decodes.
    // *****************************************************************
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    logic rd_go;  // A read is taken this cycle.
    logic wr_go;  // A write is taken this cycle.

    assign rd_go = bus_cs & bus_rd;
    assign wr_go = bus_cs & ~bus_rd;

    // Strobes are plain gates; the main module registers every effect.
    always_comb begin
        acc.wr_cnt_lo = wr_go & hit(bus_addr, `ITX_OFF_CNT_LO);
        acc.wr_cnt_hi = wr_go & hit(bus_addr, `ITX_OFF_CNT_HI);
        acc.wr_lat_lo = wr_go & hit(bus_addr, `ITX_OFF_LAT_LO);
        acc.wr_lat_hi = wr_go & hit(bus_addr, `ITX_OFF_LAT_HI);
        acc.wr_aux    = wr_go & hit(bus_addr, `ITX_OFF_AUX);
        acc.rd_cnt_lo = rd_go & hit(bus_addr, `ITX_OFF_CNT_LO);
        // The high counter byte answers at both of its offsets.
        acc.rd_cnt_hi = rd_go & (hit(bus_addr, `ITX_OFF_CNT_HI) | hit(bus_addr, `ITX_OFF_LAT_HI));
        acc.rd_lat_lo = rd_go & hit(bus_addr, `ITX_OFF_LAT_LO);
        acc.rd_aux    = rd_go & hit(bus_addr, `ITX_OFF_AUX);
    end

endmodule

// *** core/itx_map.svh ***
/*
 * Offsets, field positions, reset values and fixed figures of the interval timer one block.
 * Assumes that it is included by its bare name by the design modules.
 */
`ifndef ITX_MAP_SVH
`define ITX_MAP_SVH

// *****************************************************************
// Register offsets on the parallel register bus.
// *****************************************************************
`define ITX_OFF_CNT_LO   4'h4
`define ITX_OFF_CNT_HI   4'h5
`define ITX_OFF_LAT_LO   4'h6
`define ITX_OFF_LAT_HI   4'h7
`define ITX_OFF_AUX      4'hB

// *****************************************************************
// Field positions in the auxiliary control register.
// *****************************************************************
`define ITX_AUX_FREE_RUN 6
`define ITX_AUX_OUT_EN   7
`define ITX_AUX_UNIT_MSB 5

// *****************************************************************
// Reset values and fixed figures.
// *****************************************************************
`define ITX_RST_BYTE     8'h00
`define ITX_RST_COUNT    16'h0000
`define ITX_RST_AUX      8'h00
`define ITX_WAVE_IDLE    1'b1
`define ITX_CNT_ZERO     16'h0000
`define ITX_CNT_STEP     16'h0001
`define ITX_RD_IDLE      8'h00

`endif

// *** core/itx_pkg.sv ***
/*
 * Types shared by the interval timer one block: the access strobes, the fields handed to
 * the neighbouring units and the state record of the timer.
 * Assumes the offset header is on the include path.
 */
package itx_pkg;

    // *****************************************************************
    // One-cycle access strobes decoded from the register bus.
    // *****************************************************************
    typedef struct packed {
        logic wr_cnt_lo;   // Write of the low counter byte.
        logic wr_cnt_hi;   // Write of the high counter byte.
        logic wr_lat_lo;   // Write of the low reload latch.
        logic wr_lat_hi;   // Write of the high reload latch.
        logic wr_aux;      // Write of the auxiliary control register.
        logic rd_cnt_lo;   // Read of the low counter byte.
        logic rd_cnt_hi;   // Read of the high counter byte, at either offset.
        logic rd_lat_lo;   // Read of the low reload latch.
        logic rd_aux;      // Read of the auxiliary control register.
    } itx_acc_t;

    // *****************************************************************
    // Auxiliary control fields that belong to the other units.
    // *****************************************************************
    typedef struct packed {
        logic       timer_two_mode;  // Interval timer two pulse counting select.
        logic [2:0] shift_mode;      // Shift register mode, eight encodings.
        logic       latch_port_b;    // Port B input latching enable.
        logic       latch_port_a;    // Port A input latching enable.
    } itx_aux_t;

    // *****************************************************************
    // Whole state of the timer, registered as one record.
    // *****************************************************************
    typedef struct packed {
        logic [15:0] count;     // The 16-bit down-counter.
        logic [7:0]  latch_lo;  // Low reload latch.
        logic [7:0]  latch_hi;  // High reload latch.
        logic [7:0]  aux;       // Auxiliary control register.
        logic        running;   // Set by the first high counter load.
        logic        armed;     // The one-shot flag may still be set.
        logic        flag;      // Timer one flag.
        logic        wave;      // Level of the port B bit 7 output.
        logic        irq_n;     // Interrupt request, active low.
        logic [7:0]  rdata;     // Read data held for the host.
        logic        rdata_oe;  // The block drives the data bus.
    } itx_state_t;

endpackage

// *** core/itx_timer_one.sv ***
/*
 * Interval timer one: a 16-bit down-counter with two reload latches, one-shot and free-run
 * operation, an output on port B bit 7 and the timer one flag with its interrupt request.
 * Assumes the register bus and the flag clear and enable inputs are synchronous to clk,
 * and that the interrupt flag and enable registers live in the surrounding logic.
 */
`timescale 1ns/1ps
`include "itx_map.svh"

module itx_timer_one (
    input  wire logic               clk,           // Phase two clock, 10 MHz.
    input  wire logic               rst_n,         // Asynchronous reset, active low.
    input  wire logic               bus_cs,        // Access strobe, one cycle per access.
    input  wire logic               bus_rd,        // High for a read, low for a write.
    input  wire logic [3:0]         bus_addr,      // Register offset.
    input  wire logic [7:0]         bus_wdata,     // Write data.
    output logic      [7:0]         bus_rdata,     // Read data, one cycle after the access.
    output logic                    bus_rdata_oe,  // High while the block drives the data bus.
    input  wire logic               flag_clear,    // Direct write of the flag bit, one cycle.
    input  wire logic               irq_enable,    // Timer one interrupt enable level.
    output logic                    timer_one_flag,       // Timer one flag.
    output logic                    interrupt_request_n,  // Interrupt request, active low.
    output logic                    port_b_bit7_output,   // Timer level for port B bit 7.
    output logic                    port_b_bit7_timer_oe, // Timer owns port B bit 7.
    output itx_pkg::itx_aux_t       aux_fields     // Auxiliary fields of the other units.
);

    // *****************************************************************
    // Declarations.
    // *****************************************************************
    itx_pkg::itx_state_t st_reg;    // Registered state.
    itx_pkg::itx_state_t st_next;   // Next state.
    itx_pkg::itx_acc_t   acc;       // Decoded access strobes.
    logic                zero_ev;   // The running counter stands at zero.
    logic                free_run;  // Continuous operation selected.
    logic                out_en;    // Timer output on port B bit 7 enabled.
    logic                flag_set;  // The flag is set this cycle.
    logic                flag_clr;  // The flag is cleared this cycle.

    // *****************************************************************
    // Access decoding.
    // *****************************************************************
    itx_decode u_decode (
        .bus_cs   (bus_cs),
        .bus_rd   (bus_rd),
        .bus_addr (bus_addr),
        .acc      (acc)
    );

    // *****************************************************************
    // Event terms shared by the next-state logic and the checks.
    // *****************************************************************
    assign free_run = st_reg.aux[`ITX_AUX_FREE_RUN];
    assign out_en   = st_reg.aux[`ITX_AUX_OUT_EN];
    // The counter only times out once software has loaded it.
    assign zero_ev  = st_reg.running & (st_reg.count == `ITX_CNT_ZERO);
    // A one-shot timeout sets the flag only while still armed.
    assign flag_set = zero_ev & (free_run | st_reg.armed);
    // Reading the high byte or the latch is deliberately missing here.
    assign flag_clr = acc.rd_cnt_lo | acc.wr_cnt_hi | acc.wr_lat_hi | flag_clear;

    // *****************************************************************
    // Next-state logic.
    // *****************************************************************
    // All effects of an access land at the edge that takes it.
    always_comb begin
        st_next = st_reg;

        // Counter: a high byte load beats both reload and decrement.
        if (acc.wr_cnt_hi) begin
            // Low latch moves across as the high byte arrives.
            st_next.count   = {bus_wdata, st_reg.latch_lo};
            st_next.running = 1'b1;
            st_next.armed   = 1'b1;
            if (out_en) begin
                st_next.wave = 1'b0;
            end
        end else if (zero_ev && free_run) begin
            // Free-run reload uses whatever the latches hold now.
            st_next.count = {st_reg.latch_hi, st_reg.latch_lo};
        end else if (st_reg.running) begin
            // One-shot rolls through all ones and keeps counting.
            st_next.count = st_reg.count - `ITX_CNT_STEP;
        end

        // Output level and arming at a timeout not overridden by a load.
        if (zero_ev && !acc.wr_cnt_hi) begin
            if (free_run) begin
                if (out_en) begin
                    st_next.wave = ~st_reg.wave;
                end
            end else if (st_reg.armed) begin
                st_next.armed = 1'b0;
                if (out_en) begin
                    st_next.wave = 1'b1;
                end
            end
        end

        // Latches: plain stores that never touch the running count.
        if (acc.wr_cnt_lo || acc.wr_lat_lo) begin
            st_next.latch_lo = bus_wdata;
        end
        if (acc.wr_cnt_hi || acc.wr_lat_hi) begin
            st_next.latch_hi = bus_wdata;
        end
        if (acc.wr_aux) begin
            st_next.aux = bus_wdata;
        end

        // Flag: a timeout in the same cycle as a clear still wins.
        st_next.flag  = flag_set | (st_reg.flag & ~flag_clr);
        st_next.irq_n = ~(st_next.flag & irq_enable);

        // Read data: counter values as they stand at the access edge.
        st_next.rdata_oe = 1'b1;
        if (acc.rd_cnt_lo) begin
            st_next.rdata = st_reg.count[7:0];
        end else if (acc.rd_cnt_hi) begin
            st_next.rdata = st_reg.count[15:8];
        end else if (acc.rd_lat_lo) begin
            st_next.rdata = st_reg.latch_lo;
        end else if (acc.rd_aux) begin
            st_next.rdata = st_reg.aux;
        end else begin
            // Other offsets belong to neighbours, so the bus is released.
            st_next.rdata    = `ITX_RD_IDLE;
            st_next.rdata_oe = 1'b0;
        end
    end

    // *****************************************************************
    // State register.
    // *****************************************************************
    // Reset values are constants; the counter stays idle until loaded.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.count    <= `ITX_RST_COUNT;
            st_reg.latch_lo <= `ITX_RST_BYTE;
            st_reg.latch_hi <= `ITX_RST_BYTE;
            st_reg.aux      <= `ITX_RST_AUX;
            st_reg.running  <= 1'b0;
            st_reg.armed    <= 1'b0;
            st_reg.flag     <= 1'b0;
            st_reg.wave     <= `ITX_WAVE_IDLE;
            st_reg.irq_n    <= 1'b1;
            st_reg.rdata    <= `ITX_RD_IDLE;
            st_reg.rdata_oe <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // *****************************************************************
    // Outputs, each straight from the state register.
    // *****************************************************************
    assign bus_rdata            = st_reg.rdata;
    assign bus_rdata_oe         = st_reg.rdata_oe;
    assign timer_one_flag       = st_reg.flag;
    assign interrupt_request_n  = st_reg.irq_n;
    assign port_b_bit7_output   = st_reg.wave;
    // With bit seven clear the port register keeps the pin.
    assign port_b_bit7_timer_oe = st_reg.aux[`ITX_AUX_OUT_EN];
    assign aux_fields           = st_reg.aux[`ITX_AUX_UNIT_MSB:0];

    // *****************************************************************
    // Checks.
    // *****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A loaded counter counts down by exactly one when nothing else acts.
    property p_count_down;
        st_reg.running && !zero_ev && !acc.wr_cnt_hi
            |=> st_reg.count == $past(st_reg.count) - `ITX_CNT_STEP;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("Counter did not decrement by one.");

    // The request follows the flag in the same cycle and the enable one cycle later.
    property p_irq;
        ##1 interrupt_request_n == !(st_reg.flag && $past(irq_enable));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt request does not match flag and enable.");

    // A low counter or latch write stores the byte and leaves the counter alone.
    property p_low_write;
        (acc.wr_cnt_lo || acc.wr_lat_lo) && !zero_ev && st_reg.running
            |=> st_reg.latch_lo == $past(bus_wdata)
                && st_reg.count == $past(st_reg.count) - `ITX_CNT_STEP;
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("Low write did more than fill the low latch.");

    // A low counter read returns the count and clears the flag.
    property p_low_read;
        acc.rd_cnt_lo && !flag_set
            |=> bus_rdata == $past(st_reg.count[7:0]) && bus_rdata_oe && !timer_one_flag;
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("Low counter read gave wrong data or kept the flag.");

    // A high counter write loads all sixteen bits and restarts counting after it.
    sequence s_load_then_step;
        (st_reg.count == {$past(bus_wdata), $past(st_reg.latch_lo)}) ##1
        (st_reg.count == $past(st_reg.count) - `ITX_CNT_STEP || $past(zero_ev)
            || $past(acc.wr_cnt_hi));
    endsequence
    property p_high_load;
        acc.wr_cnt_hi |=> s_load_then_step;
    endproperty
    a_high_load: assert property (p_high_load)
        else $error("High counter write did not load and start the counter.");

    // High byte reads return the counter and keep the flag.
    property p_high_read;
        acc.rd_cnt_hi && !flag_clr
            |=> bus_rdata == $past(st_reg.count[15:8]) && timer_one_flag >= $past(st_reg.flag);
    endproperty
    a_high_read: assert property (p_high_read)
        else $error("High byte read wrong or flag lost.");

    // A low latch read returns the latch and keeps the flag.
    property p_latch_read;
        acc.rd_lat_lo && !flag_clr
            |=> bus_rdata == $past(st_reg.latch_lo) && timer_one_flag >= $past(st_reg.flag);
    endproperty
    a_latch_read: assert property (p_latch_read)
        else $error("Low latch read wrong or flag lost.");

    // A high latch write stores the byte, clears the flag and spares the counter.
    property p_high_latch;
        acc.wr_lat_hi && !flag_set && !zero_ev && st_reg.running
            |=> st_reg.latch_hi == $past(bus_wdata) && !timer_one_flag
                && st_reg.count == $past(st_reg.count) - `ITX_CNT_STEP;
    endproperty
    a_high_latch: assert property (p_high_latch)
        else $error("High latch write misbehaved.");

    // One-shot output goes low on load with bit seven set.
    property p_shot_low;
        acc.wr_cnt_hi && out_en |=> !port_b_bit7_output;
    endproperty
    a_shot_low: assert property (p_shot_low)
        else $error("One-shot output did not drop at load.");

    // A disarmed one-shot never sets the flag again.
    property p_once;
        zero_ev && !free_run && !st_reg.armed && !st_reg.flag |=> !timer_one_flag;
    endproperty
    a_once: assert property (p_once)
        else $error("One-shot flag set twice for one load.");

    // Free-run timeout reloads from both latches and toggles the enabled output.
    property p_free_reload;
        zero_ev && free_run && out_en && !acc.wr_cnt_hi
            |=> st_reg.count == {$past(st_reg.latch_hi), $past(st_reg.latch_lo)}
                && port_b_bit7_output != $past(st_reg.wave) && timer_one_flag;
    endproperty
    a_free_reload: assert property (p_free_reload)
        else $error("Free-run timeout did not reload, toggle and flag.");

    // A direct clear drops the flag unless a timeout lands with it.
    property p_direct_clear;
        flag_clear && !flag_set |=> !timer_one_flag;
    endproperty
    a_direct_clear: assert property (p_direct_clear)
        else $error("Direct flag clear was ignored.");

    property p_cov_shot;
        zero_ev && !free_run && st_reg.armed;
    endproperty
    c_cov_shot: cover property (p_cov_shot);

    property p_cov_free;
        zero_ev && free_run && out_en;
    endproperty
    c_cov_free: cover property (p_cov_free);

    property p_cov_retrigger;
        acc.wr_cnt_hi && st_reg.running && !zero_ev;
    endproperty
    c_cov_retrigger: cover property (p_cov_retrigger);

    property p_cov_race;
        flag_set && flag_clr;
    endproperty
    c_cov_race: cover property (p_cov_race);

endmodule

// *** testbench/itx_host_model.sv ***
/*
 * Host processor model: makes single accesses on the timer's register bus.
 * Assumes clk is the block clock and that the testbench calls its task.
 */
`timescale 1ns/1ps

module itx_host_model (
    input  wire logic       clk,         // Block clock.
    output logic            cs = 1'b0,   // Access strobe.
    output logic            rd = 1'b0,   // Read select.
    output logic [3:0]      addr = 4'h0, // Register offset.
    output logic [7:0]      wdata = 8'h00, // Write data.
    input  wire logic [7:0] rdata,       // Read data.
    input  wire logic       oe           // Read data valid.
);
    // ********************************************************
    // One access: set after a falling edge, taken at the next rising edge.
    // ********************************************************
    // The answer stands a single cycle, so it is taken at the very next falling edge.
    // Write data is inverted on release so a stale byte is never mistaken for live data.
    task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
        @(negedge clk);
        {cs, rd, addr, wdata} = {1'b1, r, a, d};
        @(negedge clk);
        cs = 1'b0;
        wdata = ~d;
        q = rdata;
        v = oe;
    endtask
endmodule

// *** testbench/itx_timer_one_tb.sv ***
/*
 * Self-checking testbench of the interval timer one block.
 * Assumes the package, the map header and the host model are compiled first.
 */
`timescale 1ns/1ps

module itx_timer_one_tb;
    logic              clk = 1'b0;        // 10 MHz clock.
    logic              rst_n = 1'b0;      // Reset, active low.
    logic              flag_clear = 1'b0; // Direct flag clear pulse.
    logic              irq_enable = 1'b0; // Interrupt enable level.
    logic              cs, rd, oe, flag, irq_n, pb7, pb7_oe, v;
    logic [3:0]        addr;              // Offset from the host.
    logic [7:0]        wdata, rdata, q;   // Bus bytes.
    itx_pkg::itx_aux_t aux;               // Fields for the other units.
    int                mismatches = 0;    // Failed comparisons.
    int                n_compared = 0;    // All comparisons.
    int                k;                 // Measured cycle count.

    always #50 clk = ~clk;

    itx_host_model host (.clk(clk), .cs(cs), .rd(rd), .addr(addr), .wdata(wdata),
                         .rdata(rdata), .oe(oe));
    itx_timer_one dut (.clk(clk), .rst_n(rst_n), .bus_cs(cs), .bus_rd(rd), .bus_addr(addr),
        .bus_wdata(wdata), .bus_rdata(rdata), .bus_rdata_oe(oe), .flag_clear(flag_clear),
        .irq_enable(irq_enable), .timer_one_flag(flag), .interrupt_request_n(irq_n),
        .port_b_bit7_output(pb7), .port_b_bit7_timer_oe(pb7_oe), .aux_fields(aux));

    // ********************************************************
    // Shared helpers.
    // ********************************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.acc(1'b0, a, d, q, v);
    endtask
    task automatic rdb(input logic [3:0] a);
        host.acc(1'b1, a, 8'h00, q, v);
    endtask
    // Counts falling edges until the flag is seen; bounded so a dead timer cannot hang.
    task automatic wait_flag();
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (flag !== 1'b1 && k < 300);
    endtask

    // ********************************************************
    // Scenarios.
    // ********************************************************
    task automatic t_reset();
        chk("flag", flag, 0);
        chk("irq_n", irq_n, 1);
        chk("pb7", pb7, 1);
        rdb(4'h2);
        chk("unmapped oe", v, 0);
        $display("test reset done");
    endtask
    task automatic t_oneshot();
        wr(4'hB, 8'h80);
        chk("pb7 owned", pb7_oe, 1);
        wr(4'h4, 8'h05);
        wr(4'h5, 8'h00);
        chk("pb7 low", pb7, 0);
        wait_flag();
        chk("one-shot time", k, 6);
        chk("pb7 high", pb7, 1);
        chk("irq masked", irq_n, 1);
        rdb(4'h6);
        chk("latch low", q, 8'h05);
        chk("flag kept", flag, 1);
        rdb(4'h5);
        chk("rolled high", q, 8'hFF);
        rdb(4'h4);
        chk("flag cleared", flag, 0);
        // Wait past the roll-over through zero, where a second timeout would land.
        repeat (65540) @(negedge clk);
        chk("no second flag", flag, 0);
        $display("test one-shot done");
    endtask
    task automatic t_freerun();
        irq_enable = 1'b1;
        wr(4'hB, 8'hC0);
        wr(4'h6, 8'h03);
        wr(4'h5, 8'h00);
        wait_flag();
        chk("first period", k, 4);
        chk("irq low", irq_n, 0);
        chk("pb7 toggled", pb7, 1);
        wr(4'h7, 8'h01);
        chk("latch high clears", flag, 0);
        wait_flag();
        chk("pb7 toggled back", pb7, 0);
        flag_clear = 1'b1;
        @(negedge clk);
        flag_clear = 1'b0;
        chk("direct clear", flag, 0);
        wait_flag();
        chk("new latch period", k, 259);
        rdb(4'h4);
        $display("test free-run done");
    endtask
    task automatic t_retrig();
        irq_enable = 1'b0;
        wr(4'hB, 8'h00);
        wr(4'h6, 8'h08);
        repeat (6) wr(4'h5, 8'h00);
        chk("retriggered", flag, 0);
        wr(4'h4, 8'h20);
        rdb(4'h6);
        chk("low latch", q, 8'h20);
        wait_flag();
        chk("undisturbed", k, 5);
        $display("test retrigger done");
    endtask
    task automatic t_aux();
        wr(4'hB, 8'h3F);
        chk("aux fields", 16'(aux), 16'h003F);
        chk("pb7 released", pb7_oe, 0);
        rdb(4'hB);
        chk("aux read", q, 8'h3F);
        $display("test aux done");
    endtask

    // ********************************************************
    // Verdict, main sequence and watchdog.
    // ********************************************************
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_oneshot();
        t_freerun();
        t_retrig();
        t_aux();
        final_report();
    end
    // The tests take about sixty-six thousand cycles; ninety thousand means a hang.
    initial begin
        #9000000;
        mismatches++;
        final_report();
    end
endmodule
